// file: common/cod_pkg.sv
/*
  package for the cpu opcode decoder: addressing modes, opcodes, sequencer
  states, packed carriers and timing counts.
  assumes a single 200 MHz core clock and no software-visible registers.
*/
package cod_pkg;

  // ----------------------------------------------------------------
  // addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    COD_MODE_INH  = 4'h0, // implied_operand_mode
    COD_MODE_IMM  = 4'h1, // literal_operand_mode
    COD_MODE_DIR  = 4'h2,
    COD_MODE_EXT  = 4'h3, // full_address_mode
    COD_MODE_IX   = 4'h4,
    COD_MODE_IX1  = 4'h5, // indexed_short_offset_mode
    COD_MODE_IX2  = 4'h6, // indexed_long_offset_mode
    COD_MODE_REL  = 4'h7,
    COD_MODE_BTB  = 4'h8  // direct address then relative offset
  } cod_mode_e;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    COD_ST_FETCH = 3'h0,
    COD_ST_OPND1 = 3'h1,
    COD_ST_OPND2 = 3'h2,
    COD_ST_EXEC  = 3'h3,
    COD_ST_IDLE  = 3'h4
  } cod_state_e;

  // ----------------------------------------------------------------
  // opcodes and nibble values handled here
  // ----------------------------------------------------------------
  localparam logic [7:0] COD_OP_IDX_TO_ACC = 8'h9f; // index_to_acc_transfer
  localparam logic [7:0] COD_OP_IDLE       = 8'h8f;
  localparam logic [3:0] COD_HI_BITBR      = 4'h0;
  localparam logic [3:0] COD_HI_BITSET     = 4'h1;
  localparam logic [3:0] COD_HI_REL        = 4'h2;
  localparam logic [3:0] COD_HI_DIR        = 4'h3;
  localparam logic [3:0] COD_HI_INHA       = 4'h4;
  localparam logic [3:0] COD_HI_INHX       = 4'h5;
  localparam logic [3:0] COD_HI_IX1        = 4'h6;
  localparam logic [3:0] COD_HI_IX         = 4'h7;
  localparam logic [3:0] COD_HI_CTL0       = 4'h8;
  localparam logic [3:0] COD_HI_CTL1       = 4'h9;
  localparam logic [3:0] COD_HI_IMM        = 4'ha;
  localparam logic [3:0] COD_HI_RDIR       = 4'hb;
  localparam logic [3:0] COD_HI_REXT       = 4'hc;
  localparam logic [3:0] COD_HI_RIX2       = 4'hd;
  localparam logic [3:0] COD_HI_RIX1       = 4'he;
  localparam logic [3:0] COD_LO_BSR        = 4'hd;

  // condition_code_reg field positions
  localparam int COD_CC_I = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int COD_CLK_NS      = 5;
  localparam int COD_INH_CYCLES  = 2;      // both inherent ops take two cycles
  localparam logic [1:0] COD_INH_EXTRA = 2'(COD_INH_CYCLES - 1);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] column;  // upper nibble
    logic [3:0] row;     // lower nibble
  } cod_opcode_s;

  typedef struct packed {
    cod_mode_e   mode;
    cod_opcode_s opcode;
    logic [15:0] eff_addr;
    logic [7:0]  operand;
    logic [15:0] branch_target;
  } cod_decode_s;

endpackage

// file: logic/cod_ea_adder.sv
/*
  effective address adder: 16-bit base plus offset, offset optionally a
  sign-extended byte. assumes purely combinational use by the decoder.
*/
`timescale 1ns/1ps
module cod_ea_adder (
  // operands
  input  wire logic [15:0] base_i,
  input  wire logic [15:0] offset_i,
  input  wire logic        sign_byte_i,
  // result
  output logic      [15:0] sum_o
);

  logic [15:0] ext_off;

  // widen the offset; a signed byte takes its sign bit into the top
  always_comb begin
    if (sign_byte_i) begin
      ext_off = {{8{offset_i[7]}}, offset_i[7:0]};
    end else begin
      ext_off = offset_i;
    end
    sum_o = 16'(base_i + ext_off);
  end

endmodule

// file: logic/cod_decoder.sv
/*
  cpu opcode decoder: fetches opcode bytes from program memory, picks the
  addressing mode from the nibbles, gathers operand bytes and forms the
  effective or branch address. assumes program memory answers a read in the
  same cycle (combinational read data) and that the core supplies the index
  register and the taken decision for branches.
*/
`timescale 1ns/1ps
module cod_decoder (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // program memory
  output logic               [15:0] pmem_addr_o,
  output logic                      pmem_rd_o,
  input  wire logic          [7:0]  pmem_data_i,
  // core state
  input  wire logic          [7:0]  index_reg_i,
  input  wire logic          [7:0]  ccr_i,
  input  wire logic                 branch_taken_i,
  input  wire logic                 irq_i,
  // decode results
  output cod_pkg::cod_decode_s      decode_o,
  output logic                      decode_valid_o,
  output logic                      acc_load_o,
  output logic               [7:0]  acc_data_o,
  output logic                      ccr_load_o,
  output logic               [7:0]  ccr_data_o,
  output logic                      cpu_clk_stop_o,
  output logic               [15:0] pc_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cod_pkg::cod_state_e  state, next_state;
  cod_pkg::cod_opcode_s opc, next_opc;
  cod_pkg::cod_mode_e   mode, next_mode;
  logic [15:0] pc, next_pc;
  logic [7:0]  byte1, next_byte1;
  logic [7:0]  byte2, next_byte2;
  logic [1:0]  nbytes, next_nbytes;
  logic [1:0]  wait_cnt, next_wait_cnt;
  logic        valid, next_valid;
  logic        acc_ld, next_acc_ld;
  logic [7:0]  acc_d, next_acc_d;
  logic        cc_ld, next_cc_ld;
  logic [7:0]  cc_d, next_cc_d;
  logic        stop, next_stop;
  cod_pkg::cod_decode_s dec, next_dec;

  logic [15:0] ea_base, ea_off, ea_sum;
  logic        ea_sign;
  cod_pkg::cod_mode_e  dmode;
  logic [1:0]          dbytes;
  logic [2:0]          irq_sync;

  // shared adder for indexed and relative addressing
  cod_ea_adder u_ea (
    .base_i      (ea_base),
    .offset_i    (ea_off),
    .sign_byte_i (ea_sign),
    .sum_o       (ea_sum)
  );

  // ------------------------------------------------------------
  // mode decode from opcode nibbles
  // ------------------------------------------------------------
  // column picks the group, row only matters inside mixed columns
  always_comb begin
    dmode  = cod_pkg::COD_MODE_INH;
    dbytes = 2'h0;
    case (pmem_data_i[7:4])
      cod_pkg::COD_HI_BITBR: begin
        dmode  = cod_pkg::COD_MODE_BTB;
        dbytes = 2'h2;
      end
      cod_pkg::COD_HI_BITSET, cod_pkg::COD_HI_DIR, cod_pkg::COD_HI_RDIR: begin
        dmode  = cod_pkg::COD_MODE_DIR;
        dbytes = 2'h1;
      end
      cod_pkg::COD_HI_REL: begin
        dmode  = cod_pkg::COD_MODE_REL;
        dbytes = 2'h1;
      end
      cod_pkg::COD_HI_INHA, cod_pkg::COD_HI_INHX,
      cod_pkg::COD_HI_CTL0, cod_pkg::COD_HI_CTL1: begin
        dmode  = cod_pkg::COD_MODE_INH;
        dbytes = 2'h0;
      end
      cod_pkg::COD_HI_IX1, cod_pkg::COD_HI_RIX1: begin
        dmode  = cod_pkg::COD_MODE_IX1;
        dbytes = 2'h1;
      end
      cod_pkg::COD_HI_IX: begin
        dmode  = cod_pkg::COD_MODE_IX;
        dbytes = 2'h0;
      end
      cod_pkg::COD_HI_IMM: begin
        // row d of this column is the subroutine branch
        dmode  = (pmem_data_i[3:0] == cod_pkg::COD_LO_BSR) ? cod_pkg::COD_MODE_REL
                                                            : cod_pkg::COD_MODE_IMM;
        dbytes = 2'h1;
      end
      cod_pkg::COD_HI_REXT: begin
        dmode  = cod_pkg::COD_MODE_EXT;
        dbytes = 2'h2;
      end
      cod_pkg::COD_HI_RIX2: begin
        dmode  = cod_pkg::COD_MODE_IX2;
        dbytes = 2'h2;
      end
      default: begin
        dmode  = cod_pkg::COD_MODE_IX; // column f
        dbytes = 2'h0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // address arithmetic
  // ------------------------------------------------------------
  // indexed modes add the index, relative modes add the signed byte to pc
  always_comb begin
    ea_base = {8'h00, index_reg_i};
    ea_off  = {byte1, byte2};
    ea_sign = 1'b0;
    case (mode)
      cod_pkg::COD_MODE_IX2: ea_off = {byte1, byte2};
      cod_pkg::COD_MODE_IX1: ea_off = {8'h00, byte1};
      cod_pkg::COD_MODE_REL: begin
        ea_base = pc;
        ea_off  = {8'h00, byte1};
        ea_sign = 1'b1;
      end
      cod_pkg::COD_MODE_BTB: begin
        ea_base = pc;
        ea_off  = {8'h00, byte2};
        ea_sign = 1'b1;
      end
      default: ea_off = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------
  // fetch and execute sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_opc      = opc;
    next_mode     = mode;
    next_pc       = pc;
    next_byte1    = byte1;
    next_byte2    = byte2;
    next_nbytes   = nbytes;
    next_wait_cnt = wait_cnt;
    next_valid    = 1'b0;
    next_acc_ld   = 1'b0;
    next_acc_d    = acc_d;
    next_cc_ld    = 1'b0;
    next_cc_d     = cc_d;
    next_stop     = stop;
    next_dec      = dec;
    case (state)
      cod_pkg::COD_ST_FETCH: begin
        next_opc    = pmem_data_i;
        next_mode   = dmode;
        next_nbytes = dbytes;
        next_pc     = 16'(pc + 16'h0001);
        next_byte1  = 8'h00;
        next_byte2  = 8'h00;
        if (dbytes != 2'h0) begin
          next_state = cod_pkg::COD_ST_OPND1;
        end else begin
          next_wait_cnt = cod_pkg::COD_INH_EXTRA;
          next_state    = cod_pkg::COD_ST_EXEC;
        end
      end
      cod_pkg::COD_ST_OPND1: begin
        next_byte1 = pmem_data_i; // high byte or sole byte first
        next_pc    = 16'(pc + 16'h0001);
        next_state = (nbytes == 2'h2) ? cod_pkg::COD_ST_OPND2 : cod_pkg::COD_ST_EXEC;
        next_wait_cnt = 2'h1;
      end
      cod_pkg::COD_ST_OPND2: begin
        next_byte2    = pmem_data_i; // low byte second
        next_pc       = 16'(pc + 16'h0001);
        next_wait_cnt = 2'h1;
        next_state    = cod_pkg::COD_ST_EXEC;
      end
      cod_pkg::COD_ST_EXEC: begin
        next_wait_cnt = 2'(wait_cnt - 2'h1);
        if (wait_cnt <= 2'h1) begin
          next_valid             = 1'b1;
          next_dec.mode          = mode;
          next_dec.opcode        = opc;
          next_dec.operand       = byte1;
          next_dec.branch_target = pc;
          next_dec.eff_addr      = 16'h0000;
          next_state             = cod_pkg::COD_ST_FETCH;
          case (mode)
            cod_pkg::COD_MODE_EXT: next_dec.eff_addr = {byte1, byte2};
            cod_pkg::COD_MODE_DIR: next_dec.eff_addr = {8'h00, byte1};
            cod_pkg::COD_MODE_IX:  next_dec.eff_addr = {8'h00, index_reg_i};
            cod_pkg::COD_MODE_IX1, cod_pkg::COD_MODE_IX2: next_dec.eff_addr = ea_sum;
            cod_pkg::COD_MODE_REL: begin
              if (branch_taken_i) begin
                next_pc                = ea_sum;
                next_dec.branch_target = ea_sum;
              end
            end
            cod_pkg::COD_MODE_BTB: begin
              next_dec.eff_addr = {8'h00, byte1};
              if (branch_taken_i) begin
                next_pc                = ea_sum;
                next_dec.branch_target = ea_sum;
              end
            end
            default: next_dec.eff_addr = 16'h0000;
          endcase
          if (opc == cod_pkg::COD_OP_IDX_TO_ACC) begin
            next_acc_ld = 1'b1;
            next_acc_d  = index_reg_i; // condition codes not written
          end
          if (opc == cod_pkg::COD_OP_IDLE) begin
            next_cc_ld              = 1'b1;
            next_cc_d               = ccr_i;
            next_cc_d[cod_pkg::COD_CC_I] = 1'b0;
            next_stop               = 1'b1;
            next_state              = cod_pkg::COD_ST_IDLE;
          end
        end
      end
      cod_pkg::COD_ST_IDLE: begin
        // clock held until a synchronised interrupt arrives
        if (irq_sync[2] && irq_sync[1]) begin
          next_stop  = 1'b0;
          next_state = cod_pkg::COD_ST_FETCH;
        end
      end
      default: next_state = cod_pkg::COD_ST_FETCH;
    endcase
  end

  // register the sequencer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state    <= cod_pkg::COD_ST_FETCH;
      opc      <= 8'h00;
      mode     <= cod_pkg::COD_MODE_INH;
      pc       <= 16'h0000;
      byte1    <= 8'h00;
      byte2    <= 8'h00;
      nbytes   <= 2'h0;
      wait_cnt <= 2'h0;
      valid    <= 1'b0;
      acc_ld   <= 1'b0;
      acc_d    <= 8'h00;
      cc_ld    <= 1'b0;
      cc_d     <= 8'h00;
      stop     <= 1'b0;
      dec      <= '0;
    end else begin
      state    <= next_state;
      opc      <= next_opc;
      mode     <= next_mode;
      pc       <= next_pc;
      byte1    <= next_byte1;
      byte2    <= next_byte2;
      nbytes   <= next_nbytes;
      wait_cnt <= next_wait_cnt;
      valid    <= next_valid;
      acc_ld   <= next_acc_ld;
      acc_d    <= next_acc_d;
      cc_ld    <= next_cc_ld;
      cc_d     <= next_cc_d;
      stop     <= next_stop;
      dec      <= next_dec;
    end
  end

  // three-stage synchroniser on the interrupt pin
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_sync <= 3'h0;
    end else begin
      irq_sync <= {irq_sync[1:0], irq_i};
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    pmem_addr_o    = pc;
    pmem_rd_o      = (state == cod_pkg::COD_ST_FETCH) || (state == cod_pkg::COD_ST_OPND1)
                     || (state == cod_pkg::COD_ST_OPND2);
    decode_o       = dec;
    decode_valid_o = valid;
    acc_load_o     = acc_ld;
    acc_data_o     = acc_d;
    ccr_load_o     = cc_ld;
    ccr_data_o     = cc_d;
    cpu_clk_stop_o = stop;
    pc_o           = pc;
  end

endmodule

// file: tb/cod_decoder_props.sv
/*
  checker for the opcode decoder: byte timing, operand gathering and idle.
  assumes bind onto cod_decoder and a memory that answers in the same cycle.
*/
`timescale 1ns/1ps
module cod_decoder_props (
  // clock and reset
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  // program memory
  input wire logic          [15:0] pmem_addr_o,
  input wire logic                 pmem_rd_o,
  input wire logic          [7:0]  pmem_data_i,
  // core state
  input wire logic          [7:0]  index_reg_i,
  input wire logic          [7:0]  ccr_i,
  input wire logic                 branch_taken_i,
  input wire logic                 irq_i,
  // decode results
  input wire cod_pkg::cod_decode_s decode_o,
  input wire logic                 decode_valid_o,
  input wire logic                 acc_load_o,
  input wire logic          [7:0]  acc_data_o,
  input wire logic                 ccr_load_o,
  input wire logic          [7:0]  ccr_data_o,
  input wire logic                 cpu_clk_stop_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // inherent ops
  // ----------------------------------------------------------------
  chk_inh_two_cycles : assert property (
    decode_valid_o && decode_o.mode == cod_pkg::COD_MODE_INH |-> $past(pmem_data_i, 2) == decode_o.opcode)
    else $error("inherent decode not two cycles after opcode");
  chk_acc_from_index : assert property (
    acc_load_o |-> decode_valid_o && decode_o.opcode == cod_pkg::COD_OP_IDX_TO_ACC && acc_data_o == index_reg_i)
    else $error("accumulator load without index copy");
  chk_flags_kept : assert property (
    decode_valid_o && decode_o.opcode == cod_pkg::COD_OP_IDX_TO_ACC |-> acc_load_o && !ccr_load_o)
    else $error("index copy touched flags or missed load");
  chk_idle_mask_clr : assert property (
    ccr_load_o |-> decode_o.opcode == cod_pkg::COD_OP_IDLE && ccr_data_o == (ccr_i & ~(8'h01 << cod_pkg::COD_CC_I)))
    else $error("idle flag write wrong");
  chk_stop_no_fetch : assert property (
    cpu_clk_stop_o |-> !pmem_rd_o)
    else $error("fetch while clock stopped");
  chk_stop_wake : assert property (
    cpu_clk_stop_o && irq_i |-> ##[1:8] !cpu_clk_stop_o)
    else $error("no wake after interrupt");

  // ----------------------------------------------------------------
  // operand gathering
  // ----------------------------------------------------------------
  chk_ext_bytes : assert property (
    decode_valid_o && decode_o.mode == cod_pkg::COD_MODE_EXT |-> $past(pmem_data_i, 4) == decode_o.opcode
    && decode_o.eff_addr == {$past(pmem_data_i, 3), $past(pmem_data_i, 2)})
    else $error("full address bytes wrong");
  chk_ix2_sum : assert property (
    decode_valid_o && decode_o.mode == cod_pkg::COD_MODE_IX2 |->
    decode_o.eff_addr == {$past(pmem_data_i, 3), $past(pmem_data_i, 2)} + 16'(index_reg_i))
    else $error("long offset sum wrong");
  chk_ix1_sum : assert property (
    decode_valid_o && decode_o.mode == cod_pkg::COD_MODE_IX1 |->
    decode_o.eff_addr == 16'($past(pmem_data_i, 2)) + 16'(index_reg_i))
    else $error("short offset sum wrong");
  chk_btb_fields : assert property (
    decode_valid_o && decode_o.mode == cod_pkg::COD_MODE_BTB |-> $past(pmem_data_i, 4) == decode_o.opcode
    && decode_o.eff_addr == {8'h00, $past(pmem_data_i, 3)})
    else $error("bit branch address byte wrong");
  // a branch not taken leaves the target at the next instruction
  chk_rel_target : assert property (
    decode_valid_o && decode_o.mode == cod_pkg::COD_MODE_REL |->
    decode_o.branch_target == 16'($past(pmem_addr_o, 2) + 16'h0001
    + ($past(branch_taken_i) ? 16'(signed'($past(pmem_data_i, 2))) : 16'h0000)))
    else $error("relative target wrong");
endmodule

bind cod_decoder cod_decoder_props u_cod_decoder_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o), .pmem_data_i(pmem_data_i), .index_reg_i(index_reg_i),
  .ccr_i(ccr_i), .branch_taken_i(branch_taken_i), .irq_i(irq_i), .decode_o(decode_o),
  .decode_valid_o(decode_valid_o), .acc_load_o(acc_load_o),
  .acc_data_o(acc_data_o), .ccr_load_o(ccr_load_o), .ccr_data_o(ccr_data_o), .cpu_clk_stop_o(cpu_clk_stop_o));

// file: tb/cod_pmem_model.sv
/*
  program memory model: 256 bytes, read in the same cycle.
  assumes the bench writes the contents directly before releasing reset.
*/
`timescale 1ns/1ps
module cod_pmem_model (
  // clock
  input  wire logic        sys_clk_i,
  // read port
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  data_o
);
  logic [7:0] mem [256];
  logic [7:0] last;
  // undriven bus shows the inverse of its last byte, so stale data never matches
  assign data_o = rd_i ? mem[addr_i[7:0]] : ~last;
  always_ff @(posedge sys_clk_i) begin
    last <= data_o;
  end
endmodule

// file: tb/cod_decoder_tb_top.sv
/*
  bench for the opcode decoder: random and corner programs, idle and wake.
  assumes the decoder and memory model of this folder, one 200 MHz clock.
*/
`timescale 1ns/1ps
module cod_decoder_tb_top;
  logic                 sys_clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic          [7:0]  index_reg_i = 8'h00;
  logic          [7:0]  ccr_i = 8'h00;
  logic                 irq_i = 1'b0;
  logic                 branch_taken_i = 1'b0;
  logic          [15:0] pmem_addr_o, pc_o;
  logic          [7:0]  pmem_data_i, acc_data_o, ccr_data_o;
  logic                 pmem_rd_o, decode_valid_o, acc_load_o, ccr_load_o, cpu_clk_stop_o;
  cod_pkg::cod_decode_s decode_o, e_mon;
  cod_pkg::cod_decode_s exp_q[$];
  logic          [7:0]  pos;
  int                   n_errors = 0;
  int                   samples_checked = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  cod_decoder u_cod_decoder (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pmem_addr_o(pmem_addr_o),
    .pmem_rd_o(pmem_rd_o), .pmem_data_i(pmem_data_i), .index_reg_i(index_reg_i), .ccr_i(ccr_i),
    .branch_taken_i(branch_taken_i), .irq_i(irq_i), .decode_o(decode_o), .decode_valid_o(decode_valid_o),
    .acc_load_o(acc_load_o), .acc_data_o(acc_data_o), .ccr_load_o(ccr_load_o), .ccr_data_o(ccr_data_o),
    .cpu_clk_stop_o(cpu_clk_stop_o), .pc_o(pc_o));
  cod_pmem_model u_cod_pmem_model (.sys_clk_i(sys_clk_i), .addr_i(pmem_addr_o), .rd_i(pmem_rd_o),
    .data_o(pmem_data_i));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // expected mode from the two nibbles of the opcode
  function automatic cod_pkg::cod_mode_e mode_of(input logic [7:0] op);
    case (op[7:4])
      4'h0: return cod_pkg::COD_MODE_BTB;
      4'h1, 4'h3, 4'hb: return cod_pkg::COD_MODE_DIR;
      4'h2: return cod_pkg::COD_MODE_REL;
      4'h6, 4'he: return cod_pkg::COD_MODE_IX1;
      4'h7, 4'hf: return cod_pkg::COD_MODE_IX;
      4'ha: return (op[3:0] == 4'hd) ? cod_pkg::COD_MODE_REL : cod_pkg::COD_MODE_IMM;
      4'hc: return cod_pkg::COD_MODE_EXT;
      4'hd: return cod_pkg::COD_MODE_IX2;
      default: return cod_pkg::COD_MODE_INH;
    endcase
  endfunction

  // place one instruction and queue what its decode must show
  task automatic put(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    cod_pkg::cod_decode_s e;
    int n;
    e = '0;
    e.opcode = op;
    e.mode = mode_of(op);
    n = (e.mode inside {cod_pkg::COD_MODE_BTB, cod_pkg::COD_MODE_EXT, cod_pkg::COD_MODE_IX2}) ? 3 :
        (e.mode inside {cod_pkg::COD_MODE_INH, cod_pkg::COD_MODE_IX}) ? 1 : 2;
    u_cod_pmem_model.mem[pos] = op;
    if (n > 1) u_cod_pmem_model.mem[pos + 8'h01] = b1;
    if (n > 2) u_cod_pmem_model.mem[pos + 8'h02] = b2;
    e.operand = (n > 1) ? b1 : 8'h00;
    e.eff_addr = (e.mode == cod_pkg::COD_MODE_IX1) ? 16'(b1) + 16'(index_reg_i) :
                 (e.mode == cod_pkg::COD_MODE_IX2) ? {b1, b2} + 16'(index_reg_i) :
                 (e.mode == cod_pkg::COD_MODE_EXT) ? {b1, b2} :
                 (e.mode == cod_pkg::COD_MODE_IX) ? 16'(index_reg_i) : {8'h00, b1};
    // a branch not taken leaves the target at the next instruction
    e.branch_target = 16'(pos) + 16'(n)
                      + (branch_taken_i ? 16'(signed'((e.mode == cod_pkg::COD_MODE_BTB) ? b2 : b1)) : 16'h0000);
    pos = pos + 8'(n);
    exp_q.push_back(e);
  endtask

  task automatic start_program(input logic [7:0] ccr_val);
    @(posedge sys_clk_i);
    #1;
    rst_i = 1'b1;
    exp_q.delete();
    pos = 8'h00;
    index_reg_i = 8'($urandom);
    ccr_i = ccr_val;
    branch_taken_i = 1'b0;
    for (int i = 0; i < 256; i++) u_cod_pmem_model.mem[i] = 8'h9d;
  endtask

  task automatic release_and_drain;
    repeat (3) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge sys_clk_i);
    if (exp_q.size() > 0) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic wait_stop(input logic want);
    for (int i = 0; i < 50 && cpu_clk_stop_o !== want; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (cpu_clk_stop_o !== want) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  // compare each decode pulse with the oldest queued expectation
  always @(posedge sys_clk_i) begin
    #1;
    if (rst_i === 1'b0 && decode_valid_o === 1'b1 && exp_q.size() > 0) begin
      e_mon = exp_q.pop_front();
      check(16'(decode_o.opcode), 16'(e_mon.opcode), "opcode");
      check(16'(decode_o.mode), 16'(e_mon.mode), "mode");
      check(16'(decode_o.operand), 16'(e_mon.operand), "operand");
      if (!(e_mon.mode inside {cod_pkg::COD_MODE_INH, cod_pkg::COD_MODE_IMM, cod_pkg::COD_MODE_REL}))
        check(decode_o.eff_addr, e_mon.eff_addr, "address");
      if (e_mon.mode inside {cod_pkg::COD_MODE_REL, cod_pkg::COD_MODE_BTB}) begin
        check(decode_o.branch_target, e_mon.branch_target, "target");
        check(pc_o, e_mon.branch_target, "pc");
      end
      if (e_mon.opcode == 8'h9f)
        check({7'h00, acc_load_o, acc_data_o}, {8'h01, index_reg_i}, "acc");
      if (e_mon.opcode == 8'h8f)
        check({7'h00, ccr_load_o, ccr_data_o}, {8'h01, ccr_i & 8'hf7}, "ccr");
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] op;
    void'($urandom(68946));
    repeat (20) @(posedge sys_clk_i);
    start_program(8'($urandom));
    put(8'h9f, 8'h00, 8'h00);
    put(8'hc6, 8'h12, 8'h34);
    put(8'hd6, 8'hff, 8'hff);
    put(8'he6, 8'hff, 8'h00);
    put(8'h20, 8'h80, 8'h00);
    put(8'had, 8'h7f, 8'h00);
    put(8'h0e, 8'h44, 8'hfe);
    for (int i = 0; i < 40; i++) begin
      op = 8'($urandom);
      if (op[7:4] == 4'h8) op = 8'h9f;
      put(op, 8'($urandom), 8'($urandom));
    end
    release_and_drain();
    // idle then wake, entered through a second reset, ending in a taken backward branch
    start_program(8'($urandom) | 8'h08);
    branch_taken_i = 1'b1;
    put(8'h8f, 8'h00, 8'h00);
    put(8'h9f, 8'h00, 8'h00);
    put(8'h20, 8'hf0, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    wait_stop(1'b1);
    repeat (10) @(posedge sys_clk_i);
    #1;
    check({15'h0000, pmem_rd_o}, 16'h0000, "fetch in idle");
    irq_i = 1'b1;
    wait_stop(1'b0);
    @(posedge sys_clk_i);
    #1;
    irq_i = 1'b0;
    release_and_drain();
    report_and_stop();
  end
endmodule
